// ---- logic/tisk_defs.svh ----
// Purpose: Constants for the interrupt skip and enable block
// Assumes: Included by the interface, both ends, the checker and the bench
// Notes: Register offsets are a plain index on the local port
`ifndef TISK_DEFS_SVH
`define TISK_DEFS_SVH
`define TISK_AW 4
`define TISK_OFF_IER5 4'h0
`define TISK_OFF_SKCNT 4'h1
`define TISK_OFF_SKCTL 4'h2
`define TISK_OFF_FLAGS 4'h3
`define TISK_OFF_ISTAT 4'h4
`define TISK_OFF_IMASK 4'h5
`define TISK_OFF_CMD 4'h6
`define TISK_IER5_MASK 8'h07
`define TISK_CTL_MASK 8'hFF
`define TISK_CTL_C3EN 7
`define TISK_CTL_C4EN 3
`define TISK_CTL_C3CMP 4
`define TISK_CTL_C4CMP 0
`define TISK_CNT_C3 4
`define TISK_CNT_C4 0
`define TISK_IER5_U 2
`define TISK_IER5_V 1
`define TISK_IER5_W 0
`define TISK_ST_URISE 3
`define TISK_ST_C3EV 2
`define TISK_ST_C4EV 1
`define TISK_ST_C3MT 0
`define TISK_EV_W 4
`define TISK_HOST_W 8
`endif

// ---- logic/tisk_pkg.sv ----
// Purpose: Types for the interrupt skip and enable block
// Assumes: tisk_defs.svh holds the numbers
// Notes: Host sequencer states only
package tisk_pkg;
  typedef enum logic [2:0] {
    TISK_IDLE = 3'h0,
    TISK_CLR = 3'h1,
    TISK_SET = 3'h3,
    TISK_DONE = 3'h2
  } tisk_hst_t;
endpackage : tisk_pkg

// ---- logic/tisk_if.sv ----
// Purpose: Register port between controller and timer block
// Assumes: One clock, write/read strobes, read data next cycle
// Notes: No clocking block
`timescale 1ns/100ps
`include "tisk_defs.svh"
interface tisk_if;
  logic [`TISK_AW-1:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic irq;
  modport dev (input addr, input wdata, input wr, input rd,
    output rdata, output irq);
  modport host (output addr, output wdata, output wr, output rd,
    input rdata, input irq);
endinterface : tisk_if

// ---- logic/tisk_dev.sv ----
// Purpose: Channel-5 interrupt gating and interrupt skip counter
// Assumes: Events are one-cycle pulses synchronous to mclk_i
// Notes: Skip counter is read-only; cleared via enable bits
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/100ps
`include "tisk_defs.svh"

// Function
// (R1) Enable bits 7:3 read zero
// (R2) Bit 2 gates U compare interrupt
// (R3) Bit 1 gates V compare interrupt
// (R4) Bit 0 gates W compare interrupt
// (R5) One 8-bit skip counter, holds when stopped
// (R6) Ch3 count increments on compare-A when enabled
// (R7) Ch3 count clears on match/disable/zero compare
// (R8) Ch4 count increments on over/underflow when enabled
// (R9) Ch4 count clears on match/disable/zero compare
// (R10) Counter read-only, bits 7 and 3 zero
// (R11) Clear counter by dropping both enables
// (R12) Restart: normal mode, init, disable section
// (R13) Then outputs off, setup, on, pins, start
// (R14) Synchronous; clear beats increment
module tisk_dev
  import tisk_pkg::*;
#(
  parameter int SKIP_W = 3 // Width of each skip count
)
(
  input wire logic mclk_i, // 200 MHz clock
  input wire logic sys_rst_i, // Async reset, high
  tisk_if.dev bus, // Register port
  input wire logic u_compare_flag_i, // U compare flag
  input wire logic v_compare_flag_i, // V compare flag
  input wire logic w_compare_flag_i, // W compare flag
  input wire logic ch3_compare_a_irq_i, // Ch3 compare-A pulse
  input wire logic ch4_over_underflow_irq_i, // Ch4 ovf/udf pulse
  output logic u_compare_irq_o, // Gated U request
  output logic v_compare_irq_o, // Gated V request
  output logic w_compare_irq_o // Gated W request
);
  localparam int N_PH = 3; // U, V, W phases
  localparam int N_CH = 2; // Index 0 is ch3, 1 is ch4
  logic [N_PH-1:0] ier_reg, ier_next;
  logic [7:0] ctl_reg, ctl_next;
  logic [`TISK_EV_W-1:0] sts_reg, sts_next, msk_reg, msk_next;
  logic [`TISK_EV_W-1:0] ev;
  logic irq_reg, irq_next;
  logic [7:0] rd_reg, rd_next;
  logic [7:0] cnt_word;
  wire [N_PH-1:0] flag_all;
  wire [N_PH-1:0] gate_all;
  wire [N_PH-1:0] gate_nxt_all;
  wire u_rise;
  wire [N_CH-1:0] ch_en;
  wire [N_CH-1:0] ch_en_n;
  wire [N_CH-1:0] ch_pulse;
  wire [N_CH-1:0] match_all;
  wire [N_CH-1:0][SKIP_W-1:0] ch_cmp;
  wire [N_CH-1:0][SKIP_W-1:0] ch_cmp_n;
  wire [N_CH-1:0][SKIP_W-1:0] cnt_all;

  // Phase flags placed at their enable bit positions
  assign flag_all[`TISK_IER5_U] = u_compare_flag_i;
  assign flag_all[`TISK_IER5_V] = v_compare_flag_i;
  assign flag_all[`TISK_IER5_W] = w_compare_flag_i;
  // Event pulses per skip channel
  assign ch_pulse[0] = ch3_compare_a_irq_i;
  assign ch_pulse[1] = ch4_over_underflow_irq_i;

  // Enable register: only the three gate bits are stored
  always_comb begin
    ier_next = ier_reg;
    if (bus.wr && bus.addr == `TISK_OFF_IER5) begin
      ier_next = bus.wdata[N_PH-1:0]; // R1
    end
  end
  // Enable register flops
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ier_reg <= '0;
    end else begin
      ier_reg <= ier_next;
    end
  end

  // Skip control; counters see the value being written
  always_comb begin
    ctl_next = ctl_reg;
    if (bus.wr && bus.addr == `TISK_OFF_SKCTL) begin
      ctl_next = bus.wdata & `TISK_CTL_MASK;
    end
  end
  // Skip control flops
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctl_reg <= '0;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  // Fields now and after this edge's write
  assign ch_en[0] = ctl_reg[`TISK_CTL_C3EN];
  assign ch_en[1] = ctl_reg[`TISK_CTL_C4EN];
  assign ch_en_n[0] = ctl_next[`TISK_CTL_C3EN];
  assign ch_en_n[1] = ctl_next[`TISK_CTL_C4EN];
  assign ch_cmp[0] = ctl_reg[`TISK_CTL_C3CMP +: SKIP_W];
  assign ch_cmp[1] = ctl_reg[`TISK_CTL_C4CMP +: SKIP_W];
  assign ch_cmp_n[0] = ctl_next[`TISK_CTL_C3CMP +: SKIP_W];
  assign ch_cmp_n[1] = ctl_next[`TISK_CTL_C4CMP +: SKIP_W];

  // One skip count per channel; clear beats increment
  for (genvar g = 0; g < N_CH; g++) begin : g_skip
    logic [SKIP_W-1:0] cnt_reg, cnt_next;
    logic hit;
    // A clear seen on a write takes effect on that same edge
    always_comb begin
      hit = ch_en[g] && cnt_reg == ch_cmp[g];
      cnt_next = cnt_reg; // R5
      if (!ch_en_n[g] || ch_cmp_n[g] == '0 || hit) begin
        cnt_next = '0; // R7 R9 R14
      end else if (ch_en[g] && ch_pulse[g]) begin
        cnt_next = cnt_reg + SKIP_W'(1); // R6 R8
      end
    end
    // Count flops
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        cnt_reg <= '0;
      end else begin
        cnt_reg <= cnt_next;
      end
    end
    assign cnt_all[g] = cnt_reg;
    assign match_all[g] = hit && ch_cmp[g] != '0;
  end : g_skip

  // Gated requests: flag and enable both needed
  for (genvar p = 0; p < N_PH; p++) begin : g_gate
    logic gate_reg, gate_next;
    // One cycle late, but glitch free at the output pin
    always_comb begin
      gate_next = flag_all[p] & ier_reg[p]; // R2 R3 R4
    end
    // Request flop
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        gate_reg <= 1'b0;
      end else begin
        gate_reg <= gate_next;
      end
    end
    assign gate_all[p] = gate_reg;
    assign gate_nxt_all[p] = gate_next;
  end : g_gate

  // Rising U request is the only phase event kept
  assign u_rise = gate_nxt_all[`TISK_IER5_U] & ~gate_all[`TISK_IER5_U];

  // Status, mask and interrupt level
  always_comb begin
    ev = '0;
    ev[`TISK_ST_URISE] = u_rise;
    ev[`TISK_ST_C3EV] = ch_pulse[0];
    ev[`TISK_ST_C4EV] = ch_pulse[1];
    ev[`TISK_ST_C3MT] = match_all[0];
    sts_next = sts_reg;
    msk_next = msk_reg;
    if (bus.wr && bus.addr == `TISK_OFF_ISTAT) begin
      sts_next = sts_reg & ~bus.wdata[`TISK_EV_W-1:0];
    end
    if (bus.wr && bus.addr == `TISK_OFF_IMASK) begin
      msk_next = bus.wdata[`TISK_EV_W-1:0];
    end
    // Set wins over write-one-to-clear, so no event is lost
    sts_next = sts_next | ev;
    irq_next = |(sts_next & msk_next);
  end
  // Status flops
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sts_reg <= '0;
      msk_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      sts_reg <= sts_next;
      msk_reg <= msk_next;
      irq_reg <= irq_next;
    end
  end

  // Read data; count word layout assumes the default width
  always_comb begin
    cnt_word = '0;
    cnt_word[`TISK_CNT_C3 +: SKIP_W] = cnt_all[0]; // R10
    cnt_word[`TISK_CNT_C4 +: SKIP_W] = cnt_all[1]; // R10
    rd_next = '0;
    if (bus.rd) begin
      unique case (bus.addr)
        `TISK_OFF_IER5: rd_next = {5'h00, ier_reg}; // R1
        `TISK_OFF_SKCNT: rd_next = cnt_word; // R10
        `TISK_OFF_SKCTL: rd_next = ctl_reg;
        `TISK_OFF_FLAGS: rd_next = {5'h00, gate_all};
        `TISK_OFF_ISTAT: rd_next = {4'h0, sts_reg};
        `TISK_OFF_IMASK: rd_next = {4'h0, msk_reg};
        default: rd_next = '0;
      endcase
    end
  end
  // Read data flop: zero outside the answer slot
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_reg <= '0;
    end else begin
      rd_reg <= rd_next;
    end
  end

  // Outputs straight from flops
  assign bus.rdata = rd_reg;
  assign bus.irq = irq_reg;
  assign u_compare_irq_o = gate_all[`TISK_IER5_U]; // R2
  assign v_compare_irq_o = gate_all[`TISK_IER5_V]; // R3
  assign w_compare_irq_o = gate_all[`TISK_IER5_W]; // R4
endmodule : tisk_dev

// ---- logic/tisk_host.sv ----
// Purpose: Controller end: register access and counter reset
// Assumes: Device answers reads one cycle later
// Notes: Clear command drops both skip enables then restores
`timescale 1ns/100ps
`include "tisk_defs.svh"
module tisk_host
  import tisk_pkg::*;
(
  input wire logic mclk_i, // 200 MHz clock
  input wire logic sys_rst_i, // Async reset, high
  tisk_if.host bus, // Register port
  input wire logic req_wr_i, // User write pulse
  input wire logic req_rd_i, // User read pulse
  input wire logic req_clr_i, // Skip counter clear pulse
  input wire logic [`TISK_AW-1:0] req_addr_i, // User address
  input wire logic [7:0] req_wdata_i, // User write data
  output logic [7:0] rdata_o, // Read result
  output logic rvalid_o, // Read result valid pulse
  output logic busy_o, // Clear sequence running
  output logic irq_o // Registered interrupt
);
  tisk_hst_t st_reg, st_next;
  logic [`TISK_AW-1:0] a_reg, a_next;
  logic [7:0] d_reg, d_next, ctl_reg, ctl_next, r_reg, r_next;
  logic w_reg, w_next, rd_reg, rd_next, rv_reg, rv_next, rp_reg, rp_next;
  logic irq_reg, irq_next, busy_reg, busy_next;

  // Sequencer: a clear writes the control with both enables low
  always_comb begin
    st_next = st_reg;
    a_next = a_reg;
    d_next = d_reg;
    w_next = 1'b0;
    rd_next = 1'b0;
    ctl_next = ctl_reg;
    rp_next = rd_reg;
    rv_next = rp_reg;
    r_next = rp_reg ? bus.rdata : r_reg;
    irq_next = bus.irq;
    unique case (st_reg)
      TISK_IDLE: begin
        if (req_clr_i) begin
          st_next = TISK_CLR;
        end else if (req_wr_i) begin
          w_next = 1'b1;
          a_next = req_addr_i;
          d_next = req_wdata_i;
          if (req_addr_i == `TISK_OFF_SKCTL) begin
            ctl_next = req_wdata_i;
          end
        end else if (req_rd_i) begin
          rd_next = 1'b1;
          a_next = req_addr_i;
        end
      end
      TISK_CLR: begin
        w_next = 1'b1; // R11
        a_next = `TISK_OFF_SKCTL;
        d_next = ctl_reg;
        d_next[`TISK_CTL_C3EN] = 1'b0; // R11
        d_next[`TISK_CTL_C4EN] = 1'b0;
        st_next = TISK_SET;
      end
      TISK_SET: begin
        w_next = 1'b1;
        a_next = `TISK_OFF_SKCTL;
        d_next = ctl_reg;
        st_next = TISK_DONE;
      end
      TISK_DONE: st_next = TISK_IDLE;
    endcase
    // Busy from a flop so the output carries no decode glitch
    busy_next = st_next != TISK_IDLE;
  end

  // State registers
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_reg <= TISK_IDLE;
      a_reg <= '0;
      d_reg <= 8'h00;
      w_reg <= 1'b0;
      rd_reg <= 1'b0;
      ctl_reg <= 8'h00;
      r_reg <= 8'h00;
      rv_reg <= 1'b0;
      rp_reg <= 1'b0;
      irq_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      a_reg <= a_next;
      d_reg <= d_next;
      w_reg <= w_next;
      rd_reg <= rd_next;
      ctl_reg <= ctl_next;
      r_reg <= r_next;
      rv_reg <= rv_next;
      rp_reg <= rp_next;
      irq_reg <= irq_next;
      busy_reg <= busy_next;
    end
  end

  assign bus.addr = a_reg;
  assign bus.wdata = d_reg;
  assign bus.wr = w_reg;
  assign bus.rd = rd_reg;
  assign rdata_o = r_reg;
  assign rvalid_o = rv_reg;
  assign busy_o = busy_reg;
  assign irq_o = irq_reg;
endmodule : tisk_host

// ---- testbench/tisk_asserts.sv ----
// Purpose: Bus checks for the skip and enable block
// Assumes: Plain register port, one clock
// Notes: Mirrors enable and control writes to judge reads
`timescale 1ns/100ps
`include "tisk_defs.svh"
module tisk_asserts (
  input wire logic mclk_i, // Clock
  input wire logic sys_rst_i, // Reset
  input wire logic [`TISK_AW-1:0] addr, // Index
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  input wire logic [7:0] rdata, // Read data
  input wire logic irq // Interrupt
);
  logic [7:0] ier_reg, ier_next, ctl_reg, ctl_next;
  // Mirror of written values, updated on the write edge
  always_comb begin
    ier_next = ier_reg;
    ctl_next = ctl_reg;
    if (wr && addr == 4'h0) ier_next = wdata & 8'h07;
    if (wr && addr == 4'h2) ctl_next = wdata;
  end
  // Registers only
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ier_reg <= 8'h00;
      ctl_reg <= 8'h00;
    end else begin
      ier_reg <= ier_next;
      ctl_reg <= ctl_next;
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  ier_rsvd_a: assert property (rd && addr == 4'h0 |=> !(|rdata[7:3]))
    else $error("enable reserved bits set");
  ier_back_a: assert property (rd && addr == 4'h0 |=> rdata == ier_reg)
    else $error("enable readback wrong");
  cnt_rsvd_a: assert property (rd && addr == 4'h1 |=> !rdata[7] && !rdata[3])
    else $error("counter reserved bits set");
  c3_off_a: assert property (rd && addr == 4'h1 &&
    (!ctl_reg[7] || ctl_reg[6:4] == 3'h0) |=> rdata[6:4] == 3'h0)
    else $error("ch3 count not cleared");
  c4_off_a: assert property (rd && addr == 4'h1 &&
    (!ctl_reg[3] || ctl_reg[2:0] == 3'h0) |=> rdata[2:0] == 3'h0)
    else $error("ch4 count not cleared");
  ctl_back_a: assert property (rd && addr == 4'h2 |=> rdata == ctl_reg)
    else $error("control readback wrong");
  rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
    else $error("read data outside slot");
  strobe_excl_a: assert property (!(wr && rd))
    else $error("strobes overlap");
  cover property (rd && addr == 4'h1);
  cover property ($rose(irq));
  cover property (wr && addr == 4'h2 && wdata == 8'h00);
endmodule : tisk_asserts

// ---- testbench/testbench.sv ----
// Purpose: Self-checking bench, both ends joined
// Assumes: Host answers reads with rvalid_o
// Notes: Integer model of the skip counts
`timescale 1ns/100ps
`include "tisk_defs.svh"
module testbench;
  logic mclk_i = 0, sys_rst_i = 1, rw = 0, rr = 0, rc = 0;
  logic uf = 0, vf = 0, wf = 0, e3 = 0, e4 = 0, rv, bsy, irq, u, v, w;
  logic [3:0] ad = 0;
  logic [7:0] wd = 0, rdo, got, t;
  int fails = 0, n_tests = 0, c3, c4, m3, m4, n3, n4;
  tisk_if i_tisk_if();
  tisk_dev i_tisk_dev(.mclk_i, .sys_rst_i, .bus(i_tisk_if),
    .u_compare_flag_i(uf), .v_compare_flag_i(vf), .w_compare_flag_i(wf),
    .ch3_compare_a_irq_i(e3), .ch4_over_underflow_irq_i(e4),
    .u_compare_irq_o(u), .v_compare_irq_o(v), .w_compare_irq_o(w));
  tisk_host i_tisk_host(.mclk_i, .sys_rst_i, .bus(i_tisk_if),
    .req_wr_i(rw), .req_rd_i(rr), .req_clr_i(rc), .req_addr_i(ad),
    .req_wdata_i(wd), .rdata_o(rdo), .rvalid_o(rv), .busy_o(bsy),
    .irq_o(irq));
  tisk_asserts i_tisk_asserts(.mclk_i, .sys_rst_i,
    .addr(i_tisk_if.addr), .wdata(i_tisk_if.wdata), .wr(i_tisk_if.wr),
    .rd(i_tisk_if.rd), .rdata(i_tisk_if.rdata), .irq(i_tisk_if.irq));
  // 200 MHz clock
  initial forever #2.5 mclk_i = ~mclk_i;
  task chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, s, e);
    end
  endtask : chk
  task give_verdict;
    if (fails == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  // Gap after a write lets the bus cycle land before the next request
  task wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    ad <= a; wd <= d; rw <= 1;
    @(posedge mclk_i);
    rw <= 0;
    repeat (3) @(posedge mclk_i);
  endtask : wreg
  task rreg(input logic [3:0] a);
    @(posedge mclk_i);
    ad <= a; rr <= 1;
    @(posedge mclk_i);
    rr <= 0;
    got = 8'hXX;
    repeat (8) begin
      @(negedge mclk_i);
      if (rv === 1'b1) begin
        got = rdo;
        break;
      end
    end
  endtask : rreg
  // Model applies clears on a control write
  task ctl(input int m, input int n);
    m3 = m; n3 = n;
    wreg(2, {m3[3:0], n3[3:0]});
    if (!m3[3] || m3[2:0] == 0 || c3 == m3[2:0]) c3 = 0;
    if (!n3[3] || n3[2:0] == 0 || c4 == n3[2:0]) c4 = 0;
  endtask : ctl
  // Event pulses; counts stepped in the model, cleared on match
  task ev(input logic a, input logic b);
    @(posedge mclk_i);
    e3 <= a; e4 <= b;
    @(posedge mclk_i);
    e3 <= 0; e4 <= 0;
    repeat (2) @(posedge mclk_i);
    if (a && m3[3] && m3[2:0] != 0) c3 = (c3 + 1) % 8;
    if (c3 == m3[2:0]) c3 = 0;
    if (b && n3[3] && n3[2:0] != 0) c4 = (c4 + 1) % 8;
    if (c4 == n3[2:0]) c4 = 0;
  endtask : ev
  // Watchdog, well beyond the expected run
  initial begin
    #200000;
    fails++;
    give_verdict;
  end
  initial begin
    void'($urandom(32'hb9d8));
    c3 = 0; c4 = 0; m3 = 0; n3 = 0;
    repeat (10) @(posedge mclk_i);
    sys_rst_i <= 0;
    for (int a = 0; a < 4; a++) begin
      rreg(a);
      chk(got, 8'h00);
    end
    // Every enable pattern against random flags
    for (int i = 0; i < 8; i++) begin
      t = 8'($urandom);
      wreg(0, {5'h00, i[2:0]});
      rreg(0);
      chk(got, {5'h00, i[2:0]});
      @(posedge mclk_i);
      {uf, vf, wf} <= t[2:0];
      repeat (3) @(posedge mclk_i);
      chk({5'h00, u, v, w}, {5'h00, t[2:0] & i[2:0]});
      rreg(3);
      chk(got, {5'h00, t[2:0] & i[2:0]});
    end
    // Enabled, disabled and zero-compare cases in turn
    for (int k = 0; k < 6; k++) begin
      ctl((k == 1 ? 0 : 8) + (k == 3 ? 0 : $urandom_range(7, 1)),
        (k == 2 ? 0 : 8) + (k == 4 ? 0 : $urandom_range(7, 1)));
      repeat (10) begin
        ev($urandom, $urandom);
        rreg(1);
        chk(got, {1'b0, c3[2:0], 1'b0, c4[2:0]});
      end
    end
    repeat (50) @(posedge mclk_i);
    rreg(1);
    chk(got, {1'b0, c3[2:0], 1'b0, c4[2:0]});
    wreg(1, 8'h77);
    rreg(1);
    chk(got, {1'b0, c3[2:0], 1'b0, c4[2:0]});
    ctl(15, 15);
    repeat (3) ev(1, 1);
    @(posedge mclk_i);
    rc <= 1;
    @(posedge mclk_i);
    rc <= 0;
    repeat (20) @(negedge mclk_i) if (bsy === 1'b0) break;
    chk({7'h00, bsy}, 8'h00);
    c3 = 0;
    c4 = 0;
    rreg(1);
    chk(got, {1'b0, c3[2:0], 1'b0, c4[2:0]});
    rreg(2);
    chk(got, 8'hFF);
    // Interrupt: status set, mask changes irq, write one clears
    wreg(4, 8'hFF);
    ev(1, 1);
    rreg(4);
    chk(got & 8'h06, 8'h06);
    wreg(5, 8'h00);
    chk({7'h00, irq}, 8'h00);
    wreg(5, 8'hFF);
    chk({7'h00, irq}, 8'h01);
    wreg(4, 8'hFF);
    rreg(4);
    chk(got, 8'h00);
    chk({7'h00, irq}, 8'h00);
    give_verdict;
  end
endmodule : testbench
